// [pfd_pkg.sv]
// Package with constants, register map and types of the fault and dither block.
package pfd_pkg;
    // ----------
    // Register map
    // ----------
    localparam logic [7:0] PFD_CTRL_OFS = 8'h00;
    localparam logic [7:0] PFD_INPUT_OFS = 8'h04;
    localparam logic [7:0] PFD_DITHER_OFS = 8'h08;
    localparam logic [7:0] PFD_CMP_OFS = 8'h0C;
    localparam logic [7:0] PFD_FRAC_OFS = 8'h10;
    localparam logic [7:0] PFD_CMD_OFS = 8'h14;
    localparam logic [7:0] PFD_STATUS_OFS = 8'h18;
    // ----------
    // Field positions
    // ----------
    localparam int PFD_ENABLE_BIT = 0;
    localparam int PFD_WAVEFORM_GENERATION_MODE_LSB = 4;
    localparam int PFD_MODE_B_LSB = 8;
    localparam int PFD_RESTART_BIT = 0;
    localparam int PFD_DT_B_LSB = 16;
    localparam int PFD_CLR_LSB = 12;
    localparam int PFD_STAT_HALT_BIT = 0;
    localparam int PFD_STAT_PHASE_LSB = 4;
    localparam int PFD_STAT_ACC_LSB = 8;
    // ----------
    // Reset values
    // ----------
    localparam logic [11:0] PFD_CMP_RST = 12'h010;
    localparam logic [7:0] PFD_FRAC_RST = 8'h00;
    localparam logic [3:0] PFD_MODE_RST = 4'h0;
    // ----------
    // Fault input modes handled here
    // ----------
    localparam logic [3:0] PFD_MODE_HALT = 4'h7;
    localparam logic [3:0] PFD_MODE_JUMP = 4'h8;
    localparam logic [3:0] PFD_MODE_EDGE = 4'h9;
    localparam logic [3:0] PFD_MODE_LEVEL = 4'hA;

    typedef enum logic [1:0] {
        PFD_WG_ONE_RAMP,
        PFD_WG_TWO_RAMP,
        PFD_WG_FOUR_RAMP,
        PFD_WG_DUAL_SLOPE
    } pfd_waveform_generation_mode_e;

    typedef enum logic [1:0] {
        PFD_DITH_OTB,
        PFD_DITH_OTAB,
        PFD_DITH_DTB,
        PFD_DITH_DTAB
    } pfd_dither_e;

    typedef enum logic [1:0] {
        PFD_PH_DTA,
        PFD_PH_OTA,
        PFD_PH_DTB,
        PFD_PH_OTB
    } pfd_phase_e;
endpackage

// [pfd_sync2.sv]
// Two flip-flop synchroniser for one fault input line.
`timescale 1ns/1ps
module pfd_sync2 (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic async_in,
    output logic sync_out
);
    logic stage1;
    logic next_stage1;
    logic next_sync_out;

    always_comb begin
        next_stage1 = async_in;
        next_sync_out = stage1;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stage1 <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            stage1 <= next_stage1;
            sync_out <= next_sync_out;
        end
    end
endmodule

// [pfd_fault_gate.sv]
// Output gating of one waveform output for fault input modes 9 and 10.
`timescale 1ns/1ps
module pfd_fault_gate
    import pfd_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [3:0] mode,
    input wire logic fault_level,
    input wire logic fault_rise,
    input wire logic own_on_time,
    output logic block_out
);
    logic next_block_out;

    always_comb begin
        next_block_out = block_out;
        if (!own_on_time) begin
            next_block_out = 1'b0;
        end
        if (mode == PFD_MODE_EDGE && own_on_time && fault_rise) begin
            next_block_out = 1'b1; // RQ6
        end
        if (mode == PFD_MODE_LEVEL && fault_level) begin
            next_block_out = 1'b1; // RQ7
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            block_out <= 1'b0;
        end else begin
            block_out <= next_block_out;
        end
    end
endmodule

// [pfd_top.sv]
// Fault input modes 7 to 10 and dither logic of the control PWM timer.
// Operation
// (RQ1) Mode 7: any fault event halts both outputs and counter until restart.
// (RQ2) Mode 7: fault still high at restart halts again at once.
// (RQ3) Restart after mode 7 halt always resumes at dead time A.
// (RQ4) Mode 8: input A rise in on time A ends A, jumps to B.
// (RQ5) Mode 8: input B rise in on time B ends B, jumps to A.
// (RQ6) Mode 9: rising edge blocks matching output for rest of on time.
// (RQ7) Mode 10: output off while input active and rest of that on time.
// (RQ8) Mode 10: each input gates only its own output.
// (RQ9) Dither accumulates fraction per cycle; overflow inserts one clock.
// (RQ10) Placement selects on B, on A and B, dead B, dead A and B.
// (RQ11) Added cycles depend on ramp mode and placement selection.
// (RQ12) One ramp: only output B clear compare sets cycle length; the code sums all four phase lengths in every mode.
// (RQ13) Dual slope mode: dithering has no effect.
// (RQ14) Zero-added placement shortens the following state by the inserted cycle.
// (RQ15) Each event input has its own fault input mode field.
// (RQ16) Software clears the fault before issuing restart.
//
// Local design decisions: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
module pfd_top
    import pfd_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic event_in_a,
    input wire logic event_in_b,
    output logic wave_out_a,
    output logic wave_out_b,
    output logic [1:0] counter_phase
);
    // ----------
    // Register state
    // ----------
    logic enable, next_enable;
    logic halted, next_halted;
    logic [7:0] dither_acc, next_dither_acc;
    logic [1:0] waveform_generation_mode, next_waveform_generation_mode;
    logic [3:0] fault_input_mode_a, next_mode_a;
    logic [3:0] fault_input_mode_b, next_mode_b;
    logic [1:0] dither_placement, next_dither_placement;
    logic [11:0] dead_time_a, next_dead_time_a;
    logic [11:0] dead_time_b, next_dead_time_b;
    logic [11:0] on_time_a, next_on_time_a;
    logic [11:0] out_b_clear_compare, next_clear;
    logic [7:0] dither_frac, next_dither_frac;
    logic restart_req, next_restart_req;
    logic wr_pend, next_wr_pend;
    logic [7:0] wr_addr, next_wr_addr;
    logic [31:0] next_hrdata;
    logic addr_ok;
    logic fault_a, fault_b, fault_a_q, fault_b_q;
    // ----------
    // Input synchronisers
    // ----------
    pfd_sync2 u_sync_a (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in(event_in_a),
        .sync_out(fault_a)
    );
    pfd_sync2 u_sync_b (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in(event_in_b),
        .sync_out(fault_b)
    );
    // ----------
    // AHB-Lite slave
    // ----------
    assign addr_ok = hsel && hready && htrans[1];

    always_comb begin
        next_wr_pend = addr_ok && hwrite;
        next_wr_addr = addr_ok ? haddr[7:0] : wr_addr;
        next_enable = enable;
        next_waveform_generation_mode = waveform_generation_mode;
        next_mode_a = fault_input_mode_a;
        next_mode_b = fault_input_mode_b;
        next_dither_placement = dither_placement;
        next_dead_time_a = dead_time_a;
        next_dead_time_b = dead_time_b;
        next_on_time_a = on_time_a;
        next_clear = out_b_clear_compare;
        next_dither_frac = dither_frac;
        next_restart_req = 1'b0;
        next_hrdata = hrdata;
        if (wr_pend) begin
            case (wr_addr)
                PFD_CTRL_OFS: begin
                    next_enable = hwdata[PFD_ENABLE_BIT];
                    next_waveform_generation_mode = hwdata[PFD_WAVEFORM_GENERATION_MODE_LSB +: 2];
                end
                PFD_INPUT_OFS: begin
                    next_mode_a = hwdata[3:0]; // RQ15
                    next_mode_b = hwdata[PFD_MODE_B_LSB +: 4]; // RQ15
                end
                PFD_DITHER_OFS: next_dither_placement = hwdata[1:0]; // RQ10
                PFD_CMP_OFS: begin
                    next_dead_time_a = hwdata[11:0];
                    next_dead_time_b = hwdata[PFD_DT_B_LSB +: 12];
                end
                PFD_FRAC_OFS: begin
                    next_on_time_a = hwdata[11:0];
                    next_clear = hwdata[PFD_CLR_LSB +: 12];
                    next_dither_frac = hwdata[31:24];
                end
                PFD_CMD_OFS: next_restart_req = hwdata[PFD_RESTART_BIT];
                default: next_restart_req = 1'b0;
            endcase
        end
        if (addr_ok && !hwrite) begin
            case (haddr[7:0])
                PFD_CTRL_OFS: next_hrdata = {26'h0, waveform_generation_mode,
                    3'h0, enable};
                PFD_INPUT_OFS: next_hrdata = {20'h0, fault_input_mode_b,
                    4'h0, fault_input_mode_a};
                PFD_DITHER_OFS: next_hrdata = {30'h0, dither_placement};
                PFD_CMP_OFS: next_hrdata = {4'h0, dead_time_b, 4'h0,
                    dead_time_a};
                PFD_FRAC_OFS: next_hrdata = {dither_frac,
                    out_b_clear_compare, on_time_a};
                PFD_STATUS_OFS: next_hrdata = {16'h0, dither_acc, 2'h0,
                    counter_phase, 3'h0, halted};
                default: next_hrdata = 32'h0000_0000;
            endcase
        end
    end
    // ----------
    // Counter flow, halt and dither
    // ----------
    logic [11:0] count, next_count;
    logic [1:0] next_phase;
    logic stretch, next_stretch;
    logic shorten, next_shorten;
    logic dith_ovf, next_dith_ovf;
    logic [11:0] phase_len, phase_end;
    logic rise_a, rise_b, sel_phase, adds_cycle;
    logic block_a, block_b, next_wave_a, next_wave_b;
    logic [8:0] acc_sum;

    assign rise_a = fault_a && !fault_a_q;
    assign rise_b = fault_b && !fault_b_q;

    always_comb begin
        case (counter_phase)
            PFD_PH_DTA: phase_len = dead_time_a;
            PFD_PH_OTA: phase_len = on_time_a;
            PFD_PH_DTB: phase_len = dead_time_b;
            default: phase_len = out_b_clear_compare; // RQ12
        endcase
        case (dither_placement)
            PFD_DITH_OTB: sel_phase = counter_phase == PFD_PH_OTB;
            PFD_DITH_OTAB: sel_phase = counter_phase[0]; // RQ10
            PFD_DITH_DTB: sel_phase = counter_phase == PFD_PH_DTB;
            default: sel_phase = !counter_phase[0];
        endcase
        case (waveform_generation_mode)
            PFD_WG_ONE_RAMP: adds_cycle = counter_phase == PFD_PH_OTB; // RQ11
            PFD_WG_TWO_RAMP: adds_cycle = counter_phase[0]; // RQ11
            PFD_WG_FOUR_RAMP: adds_cycle = 1'b1; // RQ11
            default: adds_cycle = 1'b0; // RQ13
        endcase
        phase_end = phase_len;
        if (stretch) begin
            phase_end = phase_len + 12'h001; // RQ9
        end else if (shorten && phase_len != 12'h000) begin
            phase_end = phase_len - 12'h001; // RQ14
        end
        acc_sum = {1'b0, dither_acc} + {1'b0, dither_frac};
        next_count = count;
        next_phase = counter_phase;
        next_halted = halted;
        next_dither_acc = dither_acc;
        next_dith_ovf = dith_ovf;
        next_stretch = stretch;
        next_shorten = shorten;
        if (!enable) begin
            next_count = 12'h000;
            next_phase = PFD_PH_DTA;
            next_halted = 1'b0;
            next_stretch = 1'b0;
            next_shorten = 1'b0;
        end else if (halted) begin
            if (restart_req) begin
                next_halted = 1'b0; // RQ1
                next_count = 12'h000;
                next_phase = PFD_PH_DTA; // RQ3
                next_stretch = 1'b0;
                next_shorten = 1'b0;
            end
        end else if ((fault_input_mode_a == PFD_MODE_HALT && fault_a) ||
                     (fault_input_mode_b == PFD_MODE_HALT && fault_b)) begin
            next_halted = 1'b1; // RQ1 RQ2
        end else if (fault_input_mode_a == PFD_MODE_JUMP && rise_a &&
                     counter_phase == PFD_PH_OTA) begin
            next_count = 12'h000;
            next_phase = PFD_PH_DTB; // RQ4
            next_stretch = 1'b0;
        end else if (fault_input_mode_b == PFD_MODE_JUMP && rise_b &&
                     counter_phase == PFD_PH_OTB) begin
            next_count = 12'h000;
            next_phase = PFD_PH_DTA; // RQ5
            next_stretch = 1'b0;
        end else if (count >= phase_end) begin
            next_count = 12'h000;
            next_phase = counter_phase + 2'd1;
            next_shorten = stretch && !adds_cycle; // RQ14
            next_stretch = 1'b0;
            if (counter_phase == PFD_PH_OTB) begin
                next_dither_acc = acc_sum[7:0]; // RQ9
                next_dith_ovf = acc_sum[8];
            end
        end else begin
            next_count = count + 12'h001;
            if (count == 12'h000) begin
                if (dith_ovf && sel_phase && waveform_generation_mode !=
                        PFD_WG_DUAL_SLOPE) begin
                    next_stretch = 1'b1; // RQ9 RQ13
                end
                if (counter_phase == PFD_PH_OTB) begin
                    next_dith_ovf = 1'b0;
                end
            end
        end
        next_wave_a = !halted && !next_halted && counter_phase == PFD_PH_OTA
            && !block_a && enable;
        next_wave_b = !halted && !next_halted && counter_phase == PFD_PH_OTB
            && !block_b && enable;
    end

    pfd_fault_gate u_gate_a (
        .hclk(hclk),
        .hresetn(hresetn),
        .mode(fault_input_mode_a),
        .fault_level(fault_a),
        .fault_rise(rise_a),
        .own_on_time(counter_phase == PFD_PH_OTA),
        .block_out(block_a)
    ); // RQ8
    pfd_fault_gate u_gate_b (
        .hclk(hclk),
        .hresetn(hresetn),
        .mode(fault_input_mode_b),
        .fault_level(fault_b),
        .fault_rise(rise_b),
        .own_on_time(counter_phase == PFD_PH_OTB),
        .block_out(block_b)
    ); // RQ8

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable <= 1'b0;
            waveform_generation_mode <= PFD_WG_ONE_RAMP;
            fault_input_mode_a <= PFD_MODE_RST;
            fault_input_mode_b <= PFD_MODE_RST;
            dither_placement <= PFD_DITH_OTB;
            dead_time_a <= PFD_CMP_RST;
            dead_time_b <= PFD_CMP_RST;
            on_time_a <= PFD_CMP_RST;
            out_b_clear_compare <= PFD_CMP_RST;
            dither_frac <= PFD_FRAC_RST;
            restart_req <= 1'b0;
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            fault_a_q <= 1'b0;
            fault_b_q <= 1'b0;
            count <= 12'h000;
            counter_phase <= PFD_PH_DTA;
            halted <= 1'b0;
            dither_acc <= 8'h00;
            dith_ovf <= 1'b0;
            stretch <= 1'b0;
            shorten <= 1'b0;
            wave_out_a <= 1'b0;
            wave_out_b <= 1'b0;
        end else begin
            enable <= next_enable;
            waveform_generation_mode <= next_waveform_generation_mode;
            fault_input_mode_a <= next_mode_a;
            fault_input_mode_b <= next_mode_b;
            dither_placement <= next_dither_placement;
            dead_time_a <= next_dead_time_a;
            dead_time_b <= next_dead_time_b;
            on_time_a <= next_on_time_a;
            out_b_clear_compare <= next_clear;
            dither_frac <= next_dither_frac;
            restart_req <= next_restart_req;
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            fault_a_q <= fault_a;
            fault_b_q <= fault_b;
            count <= next_count;
            counter_phase <= next_phase;
            halted <= next_halted;
            dither_acc <= next_dither_acc;
            dith_ovf <= next_dith_ovf;
            stretch <= next_stretch;
            shorten <= next_shorten;
            wave_out_a <= next_wave_a;
            wave_out_b <= next_wave_b;
        end
    end
endmodule

// [pfd_top_checker.sv]
// Checker of fault modes and bus response at the top ports.
`timescale 1ns/1ps
module pfd_top_checker
    import pfd_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hresp,
    input wire logic event_in_a,
    input wire logic event_in_b,
    input wire logic wave_out_a,
    input wire logic wave_out_b,
    input wire logic [1:0] counter_phase
);
    logic pend, next_pend, restart, next_restart, held;
    logic [7:0] addr, next_addr;
    logic [3:0] mode_a, next_mode_a, mode_b, next_mode_b, calm, next_calm;

    // ----------
    // Tracking of written modes, restarts and held faults
    // ----------
    always_comb begin
        held = (mode_a == 4'h7 && event_in_a) ||
            (mode_b == 4'h7 && event_in_b);
        next_pend = hsel && hready && htrans[1] && hwrite;
        next_addr = haddr[7:0];
        next_mode_a = mode_a;
        next_mode_b = mode_b;
        next_restart = 1'h0;
        next_calm = (held && !restart) ? calm + {3'h0, !calm[3]} : 4'h0;
        if (pend && addr == PFD_INPUT_OFS) begin
            next_mode_a = hwdata[3:0];
            next_mode_b = hwdata[11:8];
        end
        if (pend && addr == PFD_CMD_OFS) begin
            next_restart = hwdata[0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend <= 1'h0;
            addr <= 8'h00;
            mode_a <= PFD_MODE_RST;
            mode_b <= PFD_MODE_RST;
            restart <= 1'h0;
            calm <= 4'h0;
        end else begin
            pend <= next_pend;
            addr <= next_addr;
            mode_a <= next_mode_a;
            mode_b <= next_mode_b;
            restart <= next_restart;
            calm <= next_calm;
        end
    end

    // ----------
    // Properties
    // ----------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    AST_HRESP_OKAY: assert property (hresp == 1'h0)
        else $error("response not okay");
    AST_HALT_HOLD: assert property (
        calm[3] |-> !wave_out_a && !wave_out_b && $stable(counter_phase))
        else $error("halt does not hold");
    AST_RESTART_DTA: assert property (
        restart && (mode_a == 4'h7 || mode_b == 4'h7)
        |-> ##[0:4] counter_phase == PFD_PH_DTA)
        else $error("restart not at dead time a");
    AST_JUMP_A: assert property (
        mode_a == 4'h8 && $rose(event_in_a) && counter_phase == 2'h1
        |-> ##[1:6] counter_phase == 2'h2)
        else $error("no jump to dead time b");
    AST_JUMP_B: assert property (
        mode_b == 4'h8 && $rose(event_in_b) && counter_phase == 2'h3
        |-> ##[1:6] counter_phase == 2'h0)
        else $error("no jump to dead time a");
    AST_EDGE_BLOCK: assert property (
        mode_a == 4'h9 && $rose(event_in_a) && counter_phase == 2'h1
        ##5 counter_phase == 2'h1 |-> !wave_out_a)
        else $error("edge does not block output a");
    AST_LEVEL_GATE: assert property (
        (mode_a == 4'hA && event_in_a)[*5] |-> !wave_out_a)
        else $error("level does not gate output a");
    AST_OWN_OUTPUT: assert property (
        (mode_b == 4'h0 && mode_a != 4'h7 && counter_phase == 2'h3)[*3]
        |-> wave_out_b)
        else $error("output b disturbed");

    cover property (calm[3]);
    cover property (restart);
    cover property (mode_a == 4'h9 && $rose(event_in_a));
endmodule

bind pfd_top pfd_top_checker pfd_top_checker_inst (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .hresp, .event_in_a, .event_in_b, .wave_out_a, .wave_out_b,
    .counter_phase
);

// [pfd_event_src.sv]
// Model of the event sources that drive the two fault inputs.
`timescale 1ns/1ps
module pfd_event_src (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic slow,
    input wire logic [1:0] want,
    output logic event_in_a,
    output logic event_in_b
);
    logic [9:0] dly, next_dly;

    // Delay line that answers next cycle or five cycles later.
    always_comb begin
        next_dly = {dly[7:0], want};
        event_in_a = slow ? dly[8] : dly[0];
        event_in_b = slow ? dly[9] : dly[1];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dly <= 10'h000;
        end else begin
            dly <= next_dly;
        end
    end
endmodule

// [tb_pfd_top.sv]
// Self-checking testbench of the fault mode and dither block.
`timescale 1ns/1ps
module tb_pfd_top;
    import pfd_pkg::*;
    logic hclk = 1'h0;
    logic hresetn = 1'h0;
    logic hsel = 1'h0;
    logic hwrite = 1'h0;
    logic slow = 1'h0;
    logic [1:0] htrans = 2'h0;
    logic [1:0] want = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, q;
    logic hreadyout, hresp, event_in_a, event_in_b, wave_out_a, wave_out_b;
    logic [1:0] counter_phase;
    int num_errors = 0;
    int compares = 0;
    int add_tab[16] = '{1, 1, 0, 0, 1, 2, 0, 0, 1, 2, 1, 2, 0, 0, 0, 0};

    always #50 hclk = ~hclk;

    pfd_top pfd_top_inst (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .event_in_a,
        .event_in_b, .wave_out_a, .wave_out_b, .counter_phase
    );
    pfd_event_src pfd_event_src_inst (
        .hclk, .hresetn, .slow, .want, .event_in_a, .event_in_b
    );

    // ----------
    // Shared tasks
    // ----------
    task automatic check_val(input string n, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic stop_test;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        q = hrdata;
    endtask

    task automatic wait_ph(input logic [1:0] p);
        for (int i = 0; i < 500 && counter_phase !== p; i++) @(posedge hclk);
    endtask

    task automatic enter(input logic [1:0] p);
        wait_ph(p - 2'h1);
        wait_ph(p);
    endtask

    task automatic cfg(input logic [1:0] g, p, input logic [11:0] t,
        input logic [7:0] f);
        bus(1'h1, PFD_CMP_OFS, {4'h0, t, 4'h0, t}, q);
        bus(1'h1, PFD_FRAC_OFS, {f, t, t}, q);
        bus(1'h1, PFD_DITHER_OFS, {30'h0, p}, q);
        bus(1'h1, PFD_CTRL_OFS, {26'h0, g, 4'h1}, q);
    endtask

    // ----------
    // Scenarios
    // ----------
    task automatic t_regs;
        bus(1'h0, PFD_CMP_OFS, 32'h0, q);
        check_val("compare reset", {4'h0, PFD_CMP_RST, 4'h0, PFD_CMP_RST}, q);
        bus(1'h0, PFD_FRAC_OFS, 32'h0, q);
        check_val("fraction reset",
            {PFD_FRAC_RST, PFD_CMP_RST, PFD_CMP_RST}, q);
        bus(1'h1, 8'h20, 32'hFFFFFFFF, q);
        bus(1'h0, 8'h20, 32'h0, q);
        check_val("unmapped", 32'h0, q);
        bus(1'h1, PFD_INPUT_OFS, 32'h00000A09, q);
        bus(1'h0, PFD_INPUT_OFS, 32'h0, q);
        check_val("mode fields", 32'h00000A09, q);
        bus(1'h1, PFD_INPUT_OFS, 32'h0, q);
    endtask

    task automatic t_halt;
        int k;
        for (k = 0; k < 2; k++) begin
            bus(1'h1, PFD_INPUT_OFS, k ? 32'h700 : 32'h7, q);
            enter(2'h3);
            want <= k ? 2'h2 : 2'h1;
            repeat (40) @(posedge hclk);
            check_val("halt phase", 2'h3, counter_phase);
            check_val("halt outs", 2'h0, {wave_out_a, wave_out_b});
            bus(1'h1, PFD_CMD_OFS, 32'h1, q);
            repeat (6) @(posedge hclk);
            bus(1'h0, PFD_STATUS_OFS, 32'h0, q);
            check_val("halt again", 1'h1, q[0]);
            check_val("halt at dead a", PFD_PH_DTA, counter_phase);
            want <= 2'h0;
            repeat (6) @(posedge hclk);
            bus(1'h1, PFD_CMD_OFS, 32'h1, q);
            repeat (40) @(posedge hclk);
            check_val("resumed", PFD_PH_OTA, counter_phase);
        end
        bus(1'h1, PFD_INPUT_OFS, 32'h0, q);
    endtask

    task automatic t_jump;
        int k, n;
        for (k = 0; k < 2; k++) begin
            bus(1'h1, PFD_INPUT_OFS, k ? 32'h800 : 32'h8, q);
            enter(k ? 2'h3 : 2'h1);
            repeat (2) @(posedge hclk);
            want <= k ? 2'h2 : 2'h1;
            n = 0;
            while (counter_phase === (k ? 2'h3 : 2'h1)) begin
                @(posedge hclk);
                n++;
            end
            check_val("jump early", 1'h1, n < 10);
            check_val("jump to", k ? 2'h0 : 2'h2, counter_phase);
            want <= 2'h0;
            repeat (6) @(posedge hclk);
        end
    endtask

    task automatic t_edge;
        int n;
        bus(1'h1, PFD_INPUT_OFS, 32'h9, q);
        enter(2'h1);
        n = 0;
        do begin
            @(posedge hclk);
            n++;
            if (n == 3) check_val("on before", 1'h1, wave_out_a);
            if (n == 4) want <= 2'h1;
            if (n == 12) check_val("blocked", 1'h0, wave_out_a);
        end while (counter_phase === PFD_PH_OTA);
        check_val("on length", 33, n);
        enter(2'h1);
        repeat (6) @(posedge hclk);
        check_val("no new edge", 1'h1, wave_out_a);
        want <= 2'h0;
    endtask

    task automatic t_level;
        logic a_on, b_on;
        bus(1'h1, PFD_INPUT_OFS, 32'hA, q);
        slow <= 1'h1;
        want <= 2'h1;
        a_on = 1'h0;
        b_on = 1'h0;
        repeat (12) @(posedge hclk);
        repeat (140) begin
            @(posedge hclk);
            a_on |= wave_out_a;
            b_on |= wave_out_b;
        end
        check_val("gated", 2'h1, {a_on, b_on});
        enter(2'h1);
        repeat (5) @(posedge hclk);
        want <= 2'h0;
        while (counter_phase === PFD_PH_OTA) begin
            @(posedge hclk);
            a_on |= wave_out_a;
        end
        check_val("rest of on time", 1'h0, a_on);
        enter(2'h1);
        repeat (6) @(posedge hclk);
        check_val("next on time", 1'h1, wave_out_a);
        slow <= 1'h0;
        bus(1'h1, PFD_INPUT_OFS, 32'h0, q);
    endtask

    task automatic t_dither;
        int i, j, n, e;
        for (i = 0; i < 16; i++) begin
            cfg(i[3:2], i[1:0], 12'h003, 8'h80);
            enter(2'h0);
            enter(2'h0);
            n = 0;
            e = 64 + 2 * add_tab[i];
            for (j = 0; j < 4; j++) begin
                do begin
                    @(posedge hclk);
                    n++;
                end while (counter_phase === PFD_PH_DTA);
                do begin
                    @(posedge hclk);
                    n++;
                end while (counter_phase !== PFD_PH_DTA);
            end
            check_val("period", e, n);
        end
    endtask

    initial begin
        repeat (10000) @(posedge hclk);
        num_errors++;
        $display("unexpected timeout");
        stop_test;
    end

    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'h1;
        t_regs;
        cfg(PFD_WG_FOUR_RAMP, PFD_DITH_OTB, 12'h020, 8'h00);
        t_halt;
        t_jump;
        t_edge;
        t_level;
        t_dither;
        stop_test;
    end
endmodule
